// File: tb/sdf_host.sv
`timescale 1ns/1ns
module sdf_host (
  // serial link to the device
  output logic sclk_out,
  output logic din_out,
  output logic sync_n_out
);
  // 34 ns link period keeps the serial clock below the 30 MHz ceiling
  localparam int HALF_NS = 17;
  // a rising sync edge at start gives the bit counter a known value
  initial begin
    sclk_out = 1'b1;
    din_out = 1'b0;
    sync_n_out = 1'b0;
    #1 sync_n_out = 1'b1;
  end
  // clock idles high between frames; data flips after each rising edge so stale bits never look valid
  task automatic send(input logic [23:0] word, input int nbits);
    sync_n_out = 1'b0;
    for (int i = 23; i > 23 - nbits; i--) begin
      din_out = word[i];
      #HALF_NS sclk_out = 1'b0;
      #HALF_NS sclk_out = 1'b1;
      din_out = ~word[i];
    end
    #HALF_NS sync_n_out = 1'b1;
  endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic        core_clk_in;
  logic        reset_in;
  logic        sclk;
  logic        din;
  logic        sync_n;
  logic [15:0] code_out;
  logic [7:0]  ctrl_out;
  logic        update_out;
  int          bad_count = 0;
  int          n_checks = 0;
  sdf_host host_i (.sclk_out(sclk), .din_out(din), .sync_n_out(sync_n));
  sdf_frame sdf_frame_i (.core_clk_in(core_clk_in), .reset_in(reset_in), .sclk_in(sclk), .din_in(din),
    .sync_n_in(sync_n), .code_out(code_out), .ctrl_out(ctrl_out), .update_out(update_out));
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  task automatic compare(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // twelve core cycles cover the sync latency and the spacing between frames
  task automatic frame(input logic [23:0] w, input int n, output int pulses);
    pulses = 0;
    @(negedge core_clk_in);
    host_i.send(w, n);
    repeat (12) begin
      @(negedge core_clk_in);
      if (update_out === 1'b1) pulses++;
    end
  endtask
  task automatic t_reset();
    compare({ctrl_out, code_out}, 24'h00_0000);
  endtask
  task automatic t_write();
    int p;
    frame(24'hA5_1234, 24, p);
    compare(24'(p), 24'h00_0001);
    compare({ctrl_out, code_out}, 24'hA5_1234);
  endtask
  task automatic t_abort();
    int p;
    frame(24'h5A_EDCB, 23, p);
    compare(24'(p), 24'h00_0000);
    compare({ctrl_out, code_out}, 24'hA5_1234);
  endtask
  task automatic t_restart();
    int p;
    frame(24'hC3_F0F0, 24, p);
    compare(24'(p), 24'h00_0001);
    compare({ctrl_out, code_out}, 24'hC3_F0F0);
  endtask
  task automatic do_reset();
    reset_in = 1'b1;
    repeat (12) @(negedge core_clk_in);
    reset_in = 1'b0;
  endtask
  initial begin
    reset_in = 1'b1;
    do_reset();
    t_reset();
    t_write();
    t_abort();
    t_restart();
    do_reset();
    t_reset();
    complete_run();
  end
  // whole run is about 110 core cycles; the limit leaves ample margin
  initial begin
    #20000;
    bad_count++;
    complete_run();
  end
endmodule

// File: verilog/sdf_frame.sv
// Functional notes
// - shift each falling clock below 24 bits, count only while frame sync low
// - sample data on each falling clock up to the 24th into 24 bits
// - after 24th edge, update converter code
// - early sync rise aborts, output unchanged
// - output code zero until first valid write
`timescale 1ns/1ns
module sdf_frame (
  // core side
  input  wire logic                core_clk_in,
  input  wire logic                reset_in,
  // serial link, clocked by its own falling edges
  input  wire logic                sclk_in,
  input  wire logic                din_in,
  input  wire logic                sync_n_in,
  // converter side
  output logic [15:0]              code_out,
  output logic [7:0]               ctrl_out,
  output logic                     update_out
);

  // ---------------- link domain ----------------
  // the counter is cleared asynchronously by sync high; the serial clock may stop
  // between frames, so no link-side logic may wait for an edge after the frame
  logic [4:0]  bit_cnt_reg;
  logic [4:0]  bit_cnt_next;
  logic [23:0] shift_reg;
  logic [23:0] shift_next;
  logic [23:0] word_reg;
  logic [23:0] word_next;
  logic        done_tgl_reg;
  logic        done_tgl_next;
  logic        frame_full;

  assign frame_full = (bit_cnt_reg == sdf_pkg::LAST_BIT);

  always_comb begin
    bit_cnt_next  = bit_cnt_reg;
    shift_next    = shift_reg;
    word_next     = word_reg;
    done_tgl_next = done_tgl_reg;
    if (bit_cnt_reg <= sdf_pkg::LAST_BIT) begin
      shift_next   = {shift_reg[22:0], din_in};
      bit_cnt_next = bit_cnt_reg + 5'h01;
      if (frame_full) begin
        word_next     = {shift_reg[22:0], din_in};
        done_tgl_next = ~done_tgl_reg;
      end
    end
  end

  // further edges after the 24th are ignored until sync goes high
  always_ff @(negedge sclk_in or posedge sync_n_in) begin
    if (sync_n_in) begin
      bit_cnt_reg <= 5'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  always_ff @(negedge sclk_in) begin
    shift_reg <= shift_next;
    word_reg  <= word_next;
  end

  // the toggle must start from a known level, otherwise the serial clock alone
  // can never resolve it; clearing it with the core reset keeps both sides of the
  // crossing equal, so no false completion follows a reset in mid-run
  always_ff @(negedge sclk_in or posedge reset_in) begin
    if (reset_in) begin
      done_tgl_reg <= 1'b0;
    end else begin
      done_tgl_reg <= done_tgl_next;
    end
  end

  // ---------------- core domain ----------------
  logic [2:0]  tgl_sync_reg;
  logic [2:0]  tgl_sync_next;
  logic        seen_reg;
  logic        seen_next;
  logic [15:0] code_reg;
  logic [15:0] code_next;
  logic [7:0]  ctrl_reg;
  logic [7:0]  ctrl_next;
  logic        upd_reg;
  logic        upd_next;
  logic        new_word;
  sdf_pkg::sdf_word_s word_view;

  // word_reg is stable for many core cycles after the toggle flips
  assign word_view = word_reg;
  assign new_word  = seen_reg & (tgl_sync_reg[2] ^ tgl_sync_reg[1]);

  always_comb begin
    tgl_sync_next = {tgl_sync_reg[1:0], done_tgl_reg};
    seen_next     = 1'b1;
    code_next     = code_reg;
    ctrl_next     = ctrl_reg;
    upd_next      = 1'b0;
    if (new_word) begin
      code_next = word_view.code;
      ctrl_next = word_view.ctrl;
      upd_next  = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      tgl_sync_reg <= 3'h0;
      seen_reg     <= 1'b0;
      code_reg     <= sdf_pkg::CODE_ZERO_VOLT;
      ctrl_reg     <= 8'h00;
      upd_reg      <= 1'b0;
    end else begin
      tgl_sync_reg <= tgl_sync_next;
      seen_reg     <= seen_next;
      code_reg     <= code_next;
      ctrl_reg     <= ctrl_next;
      upd_reg      <= upd_next;
    end
  end

  assign code_out   = code_reg;
  assign ctrl_out   = ctrl_reg;
  assign update_out = upd_reg;

  // ---------------- assertions ----------------
  property p_code_hold;
    @(posedge core_clk_in) disable iff (reset_in)
      !upd_reg |-> $stable(code_reg);
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("code changed without update");

  property p_zero_after_reset;
    @(posedge core_clk_in) $fell(reset_in) |-> (code_reg == 16'h0000);
  endproperty
  a_zero_after_reset: assert property (p_zero_after_reset) else $error("code not zero after reset");

  property p_cnt_idle;
    @(negedge sclk_in) sync_n_in |-> (bit_cnt_reg == 5'h00);
  endproperty
  a_cnt_idle: assert property (p_cnt_idle) else $error("counter running with sync high");

  property p_done_on_24;
    @(negedge sclk_in) disable iff (sync_n_in)
      (bit_cnt_reg == 5'h17) |=> (done_tgl_reg != $past(done_tgl_reg));
  endproperty
  a_done_on_24: assert property (p_done_on_24) else $error("no completion on 24th edge");

  property p_no_done_early;
    @(negedge sclk_in) disable iff (sync_n_in)
      (bit_cnt_reg < 5'h17) |=> $stable(done_tgl_reg);
  endproperty
  a_no_done_early: assert property (p_no_done_early) else $error("completion before 24th edge");

  property p_shift_in;
    @(negedge sclk_in) disable iff (sync_n_in)
      (bit_cnt_reg < 5'h18) |=> (shift_reg[0] == $past(din_in));
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("data bit not shifted");

  property p_upd_pulse;
    @(posedge core_clk_in) disable iff (reset_in) upd_reg |=> !upd_reg;
  endproperty
  a_upd_pulse: assert property (p_upd_pulse) else $error("update longer than one cycle");

  property p_upd_code;
    @(posedge core_clk_in) disable iff (reset_in) upd_reg |-> (code_reg == word_reg[15:0]);
  endproperty
  a_upd_code: assert property (p_upd_code) else $error("update code mismatch");

  property p_ctrl_hold;
    @(posedge core_clk_in) disable iff (reset_in)
      !upd_reg |-> $stable(ctrl_reg);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed without update");

  property p_upd_upd_ctrl;
    @(posedge core_clk_in) disable iff (reset_in)
      upd_reg |-> (ctrl_reg == word_reg[23:16]);
  endproperty
  a_upd_upd_ctrl: assert property (p_upd_upd_ctrl) else $error("update control mismatch");

  // a completion seen by the core: the synchronised toggle flips while armed
  sequence s_tgl_arrived;
    $changed(tgl_sync_reg[1]) ##0 seen_reg;
  endsequence

  property p_upd_follows;
    @(posedge core_clk_in) disable iff (reset_in)
      s_tgl_arrived |=> upd_reg;
  endproperty
  a_upd_follows: assert property (p_upd_follows) else $error("completion not forwarded");

  property p_upd_cause;
    @(posedge core_clk_in) disable iff (reset_in)
      upd_reg |-> $past(new_word);
  endproperty
  a_upd_cause: assert property (p_upd_cause) else $error("update without completion");

  property p_reset_zero;
    @(posedge core_clk_in) reset_in |=> ((code_reg == 16'h0000) && !upd_reg);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset did not clear output");

  // the counter saturates one past the last bit so late edges cannot wrap it
  property p_cnt_sat;
    @(negedge sclk_in) bit_cnt_reg <= 5'h18;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) else $error("bit counter overran");

  property p_word_hold;
    @(negedge sclk_in) disable iff (sync_n_in)
      (bit_cnt_reg == 5'h18) |=> $stable(word_reg);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word changed after 24th edge");
endmodule

// File: verilog/sdf_pkg.sv
package sdf_pkg;
  localparam int unsigned FRAME_BITS     = 24;
  localparam int unsigned CNT_W          = 5;
  localparam int unsigned CODE_W         = 16;
  localparam logic [4:0]  LAST_BIT       = 5'h17;
  localparam logic [23:0] SHIFT_RESET    = 24'h00_0000;
  localparam logic [23:0] WORD_RESET     = 24'h00_0000;
  localparam logic [15:0] CODE_ZERO_VOLT = 16'h0000;
  localparam int unsigned CODE_MSB       = 15;
  localparam int unsigned CTRL_LSB       = 16;
  localparam int unsigned CTRL_MSB       = 23;

  typedef struct packed {
    logic       sclk;
    logic       din;
    logic       sync_n;
  } sdf_link_s;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [15:0] code;
  } sdf_word_s;
endpackage
